// *** hw/dsc_core.sv ***
// Computation core of the two-input signal calculator with register port
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "dsc_defs.svh"

module dsc_core #(
  parameter int SAMPLE_CYCLES = `DSC_SAMPLE_US * `DSC_CLK_KHZ / 1000
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic [15:0] IN_A,
  input  wire logic [15:0] IN_B,
  input  wire logic        DIG_IN,
  input  wire logic [15:0] NV_RDATA,
  output logic             NV_WR,
  output logic      [15:0] NV_WDATA,
  output logic      [15:0] OUT_VALUE,
  output logic             OUT_IS_VOLTAGE,
  output logic             OUT_UPDATE,
  output dsc_pkg::dsc_state_t STATE
);
  import dsc_pkg::*;

  // ==========================================================
  // Arithmetic helpers
  function automatic dsc_val_t sat37(input logic signed [36:0] v);
    if (v[36:19] == '0 || v[36:19] == '1) begin
      return v[19:0];
    end
    return v[36] ? `DSC_NEG_MAX : `DSC_POS_MAX;
  endfunction

  function automatic dsc_val_t addsat(input dsc_val_t a, input dsc_val_t b);
    logic signed [36:0] s;
    s = 37'(a) + 37'(b);
    return sat37(s);
  endfunction

  // Value times gain (Q4.12)
  function automatic dsc_val_t mulg(input dsc_val_t a, input logic [15:0] g);
    logic signed [36:0] p;
    p = 37'(a) * 37'($signed({1'b0, g}));
    return sat37(p >>> 12);
  endfunction

  // Value times value (Q14)
  function automatic dsc_val_t mulq(input dsc_val_t a, input dsc_val_t b);
    logic signed [39:0] p;
    p = 40'(a) * 40'(b);
    // Shift the signed product before narrowing so the sign is kept
    return sat37(37'(p >>> 14));
  endfunction

  function automatic logic [15:0] span_top(input logic [2:0] code, input logic ovr);
    case (code)
      3'h1:    span_top = ovr ? `DSC_OTOP_10MA  : `DSC_TOP_10MA;
      3'h2:    span_top = ovr ? `DSC_OTOP_20MA  : `DSC_TOP_20MA;
      3'h3:    span_top = ovr ? `DSC_OTOP_500MV : `DSC_TOP_500MV;
      3'h4:    span_top = ovr ? `DSC_OTOP_1V    : `DSC_TOP_1V;
      3'h5:    span_top = ovr ? `DSC_OTOP_5V    : `DSC_TOP_5V;
      3'h6:    span_top = ovr ? `DSC_OTOP_10V   : `DSC_TOP_10V;
      default: span_top = 16'h0000;
    endcase
  endfunction

  // ==========================================================
  // Registers
  logic [15:0] ctrl_r;
  logic [2:0]  range_r;
  logic [15:0] gain_a_r;
  logic [15:0] gain_b_r;
  logic [15:0] offset_r;
  logic [15:0] out_zero_r;
  logic [15:0] out_full_r;
  logic [15:0] pband_r;
  logic [3:0]  itime_r;
  logic [15:0] dtime_r;
  logic [15:0] setpt_r;
  logic [3:0]  dshift_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_r     <= `DSC_RST_CTRL;
      range_r    <= `DSC_RST_RANGE;
      gain_a_r   <= `DSC_RST_GAIN;
      gain_b_r   <= `DSC_RST_GAIN;
      offset_r   <= `DSC_RST_OFFSET;
      out_zero_r <= `DSC_RST_OUT_ZERO;
      out_full_r <= `DSC_RST_OUT_FULL;
      pband_r    <= `DSC_RST_PBAND;
      itime_r    <= `DSC_RST_ITIME;
      dtime_r    <= `DSC_RST_DTIME;
      setpt_r    <= `DSC_RST_SETPT;
      dshift_r   <= `DSC_RST_DSHIFT;
    end else if (WR) begin
      case (ADDR)
        `DSC_ADDR_CTRL:     ctrl_r     <= {6'h00, WDATA[9:0]};
        `DSC_ADDR_RANGE:    range_r    <= WDATA[2:0];
        `DSC_ADDR_GAIN_A:   gain_a_r   <= WDATA;
        `DSC_ADDR_GAIN_B:   gain_b_r   <= WDATA;
        `DSC_ADDR_OFFSET:   offset_r   <= (WDATA > 16'(`DSC_ONE)) ? 16'(`DSC_ONE) : WDATA;
        `DSC_ADDR_OUT_ZERO: out_zero_r <= WDATA;
        `DSC_ADDR_OUT_FULL: out_full_r <= WDATA;
        `DSC_ADDR_PBAND:    pband_r    <= WDATA;
        `DSC_ADDR_ITIME:    itime_r    <= WDATA[3:0];
        `DSC_ADDR_DTIME:    dtime_r    <= WDATA;
        `DSC_ADDR_SETPT:    setpt_r    <= WDATA;
        `DSC_ADDR_DSHIFT:   dshift_r   <= WDATA[3:0];
        default: ;
      endcase
    end
  end

  logic [4:0] func;
  logic       sel_b;
  logic       ovr_on;
  logic       pid_inv;
  logic       ext_sp;
  logic       hold_sel;
  assign func     = ctrl_r[`DSC_CTRL_FUNC_HI:0];
  assign sel_b    = ctrl_r[`DSC_CTRL_SEL_B];
  assign ovr_on   = ctrl_r[`DSC_CTRL_OVR];
  assign pid_inv  = ctrl_r[`DSC_CTRL_INV];
  assign ext_sp   = ctrl_r[`DSC_CTRL_EXT_SP];
  assign hold_sel = ctrl_r[`DSC_CTRL_HOLD];

  // ==========================================================
  // Sample period tick
  logic [31:0] tick_cnt_r;
  logic        tick_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= 32'(SAMPLE_CYCLES - 1)) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r     <= 1'b0;
    end
  end

  // ==========================================================
  // Digital input: synchroniser, then activation edge
  logic dig_s1_r;
  logic dig_s2_r;
  logic dig_d_r;
  logic act_pend_r;
  logic dig_rise;
  assign dig_rise = dig_s2_r & ~dig_d_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      dig_s1_r <= 1'b0;
      dig_s2_r <= 1'b0;
      dig_d_r  <= 1'b0;
    end else begin
      dig_s1_r <= DIG_IN;
      dig_s2_r <= dig_s1_r;
      dig_d_r  <= dig_s2_r;
    end
  end

  // Edge between ticks must not be lost; a new edge beats the clearing tick
  always_ff @(posedge CLK) begin
    if (RESET) begin
      act_pend_r <= 1'b0;
    end else if (dig_rise) begin
      act_pend_r <= 1'b1;
    end else if (tick_r) begin
      act_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // Input scaling and stateful modes
  dsc_val_t a_s;
  dsc_val_t b_s;
  dsc_val_t sa;
  dsc_val_t sb;
  dsc_val_t off_s;
  logic [15:0] sel_in;
  assign a_s    = $signed({4'h0, IN_A});
  assign b_s    = $signed({4'h0, IN_B});
  assign off_s  = $signed({4'h0, offset_r});
  assign sa     = mulg(a_s, gain_a_r);
  assign sb     = mulg(b_s, gain_b_r);
  assign sel_in = sel_b ? IN_B : IN_A;

  logic [15:0] hold_r;
  logic [15:0] peak_r;
  dsc_val_t    dly_r;
  dsc_val_t    integ_r;
  dsc_val_t    pid_r;
  dsc_val_t    pv_prev_r;
  logic        restore_r;
  logic [15:0] hold_nxt;
  logic [15:0] peak_nxt;
  dsc_val_t    dly_nxt;
  dsc_val_t    integ_nxt;
  dsc_val_t    pid_nxt;
  dsc_val_t    pv;
  dsc_val_t    err;
  dsc_val_t    dterm;
  logic        pid_hold;

  assign hold_nxt = dig_s2_r ? hold_r : sel_in;
  always_comb begin
    if (act_pend_r) begin
      peak_nxt = sel_in;
    end else if (!dig_s2_r && sel_in > peak_r) begin
      peak_nxt = sel_in;
    end else begin
      peak_nxt = peak_r;
    end
  end
  assign dly_nxt = addsat(dly_r, ($signed({4'h0, sel_in}) - dly_r) >>> dshift_r);

  // Setpoint: internal register or input B
  assign pv       = a_s;
  assign err      = pid_inv ? (ext_sp ? b_s : $signed({4'h0, setpt_r})) - pv
                            : pv - (ext_sp ? b_s : $signed({4'h0, setpt_r}));
  assign pid_hold = hold_sel & dig_s2_r;
  // Rise of the process pushes in the direction of the action
  assign dterm    = mulg(pid_inv ? pv_prev_r - pv : pv - pv_prev_r, dtime_r);

  always_comb begin
    if (pid_hold) begin
      integ_nxt = integ_r;
      pid_nxt   = pid_r;
    end else begin
      integ_nxt = (itime_r == 4'h0) ? 20'sh0 : addsat(integ_r, err >>> itime_r);
      pid_nxt   = addsat(addsat(addsat(off_s, mulg(err, pband_r)), integ_nxt),
                         (dtime_r == 16'h0) ? 20'sh0 : dterm);
    end
  end

  // Stored values come back from non-volatile storage after reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      restore_r <= 1'b1;
      hold_r    <= 16'h0000;
      peak_r    <= 16'h0000;
    end else if (restore_r) begin
      restore_r <= 1'b0;
      hold_r    <= NV_RDATA;
      peak_r    <= NV_RDATA;
    end else if (tick_r) begin
      hold_r    <= hold_nxt;
      peak_r    <= peak_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      dly_r     <= 20'sh0;
      integ_r   <= 20'sh0;
      pid_r     <= 20'sh0;
      pv_prev_r <= 20'sh0;
    end else if (tick_r) begin
      dly_r     <= dly_nxt;
      integ_r   <= integ_nxt;
      pid_r     <= pid_nxt;
      pv_prev_r <= pv;
    end
  end

  // ==========================================================
  // Non-volatile write-back, only when the held value differs from the last word written
  logic [15:0] nv_val;
  logic        nv_mode;
  assign nv_val  = (func == FN_PK) ? peak_nxt : hold_nxt;
  assign nv_mode = (func == FN_PK) || (func == FN_SH);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      NV_WR    <= 1'b0;
      NV_WDATA <= 16'h0000;
    end else if (tick_r && !restore_r && nv_mode && nv_val != NV_WDATA) begin
      NV_WR    <= 1'b1;
      NV_WDATA <= nv_val;
    end else begin
      NV_WR    <= 1'b0;
    end
  end

  // ==========================================================
  // Single-cycle functions
  dsc_val_t calc;
  always_comb begin
    case (func)
      FN_ADD:  calc = addsat(addsat(sa, sb), off_s);
      FN_SUB:  calc = addsat(sel_b ? sb - sa : sa - sb, off_s);
      FN_MAX:  calc = addsat((sa > sb) ? sa : sb, off_s);
      FN_MIN:  calc = addsat((sa < sb) ? sa : sb, off_s);
      FN_MUL:  calc = addsat(mulg(mulq(a_s, b_s), gain_a_r), off_s);
      FN_SH:   calc = $signed({4'h0, hold_nxt});
      FN_PK:   calc = $signed({4'h0, peak_nxt});
      FN_DLY:  calc = dly_nxt;
      FN_PID:  calc = pid_nxt;
      default: calc = 20'sh0;
    endcase
  end

  // ==========================================================
  // Sequencer with shared divide / root / power engine
  dsc_state_t  state_r;
  logic [4:0]  cnt_r;
  logic [30:0] rem_r;
  logic [29:0] quo_r;
  logic [14:0] root_r;
  logic [15:0] base_r;
  dsc_val_t    acc_r;
  dsc_val_t    res_r;
  logic        div_sat_r;
  logic [15:0] den;
  logic [15:0] num;
  logic [30:0] rem_sh;
  logic [14:0] trial;
  logic [29:0] trial_sq;
  logic [29:0] quo_sat;

  assign den      = sel_b ? IN_A : IN_B;
  assign num      = sel_b ? IN_B : IN_A;
  assign rem_sh   = {rem_r[29:0], quo_r[29]};
  assign trial    = root_r | (15'h1 << cnt_r[3:0]);
  assign trial_sq = 30'(trial) * 30'(trial);
  assign quo_sat  = (quo_r[29:19] != 11'h0) ? 30'h7ffff : quo_r;
  assign STATE    = state_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 5'h0;
      rem_r     <= 31'h0;
      quo_r     <= 30'h0;
      root_r    <= 15'h0;
      base_r    <= 16'h0;
      acc_r     <= 20'sh0;
      res_r     <= 20'sh0;
      div_sat_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (tick_r) begin
            if (func == FN_DIV && den < `DSC_DIV_MIN) begin
              res_r     <= `DSC_POS_MAX;
              div_sat_r <= 1'b1;
              state_r   <= ST_DONE;
            end else if (func == FN_DIV) begin
              rem_r     <= 31'h0;
              quo_r     <= {num, 14'h0};
              cnt_r     <= 5'd29;
              div_sat_r <= 1'b0;
              state_r   <= ST_DIV;
            end else if (func == FN_POW) begin
              base_r    <= sel_in;
              root_r    <= 15'h0;
              cnt_r     <= gain_b_r[11] ? 5'd14 : {1'b0, gain_b_r[15:12]};
              acc_r     <= `DSC_ONE;
              state_r   <= gain_b_r[11] ? ST_SQRT : ST_POW;
            end else begin
              res_r     <= calc;
              state_r   <= ST_DONE;
            end
          end
        end
        // Restoring division, one quotient bit per cycle
        ST_DIV: begin
          if (rem_sh >= 31'(den)) begin
            rem_r <= rem_sh - 31'(den);
            quo_r <= {quo_r[28:0], 1'b1};
          end else begin
            rem_r <= rem_sh;
            quo_r <= {quo_r[28:0], 1'b0};
          end
          if (cnt_r == 5'h0) begin
            state_r <= ST_DONE;
          end else begin
            cnt_r <= cnt_r - 5'h1;
          end
          if (cnt_r == 5'h0) begin
            res_r <= 20'sh0;
          end
        end
        // Half exponent: bitwise square root first
        ST_SQRT: begin
          if (trial_sq <= {base_r, 14'h0}) begin
            root_r <= trial;
          end
          if (cnt_r == 5'h0) begin
            acc_r   <= (trial_sq <= {base_r, 14'h0}) ? $signed({5'h0, trial}) : $signed({5'h0, root_r});
            cnt_r   <= {1'b0, gain_b_r[15:12]};
            state_r <= ST_POW;
          end else begin
            cnt_r <= cnt_r - 5'h1;
          end
        end
        // Whole part of the exponent by repeated multiply
        ST_POW: begin
          if (cnt_r == 5'h0) begin
            res_r   <= addsat(mulg(acc_r, gain_a_r), off_s);
            state_r <= ST_DONE;
          end else begin
            acc_r <= mulq(acc_r, $signed({4'h0, base_r}));
            cnt_r <= cnt_r - 5'h1;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Division result lands one cycle after the last quotient bit
  logic div_last_r;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      div_last_r <= 1'b0;
    end else begin
      div_last_r <= (state_r == ST_DIV) && (cnt_r == 5'h0);
    end
  end

  dsc_val_t fin;
  assign fin = div_last_r ? addsat(mulg($signed(quo_sat[19:0]), gain_a_r), off_s) : res_r;

  // ==========================================================
  // Output mapping and clamping
  dsc_val_t         y_lo;
  dsc_val_t         y_hi;
  dsc_val_t         y_c;
  logic signed [36:0] phys;
  logic [15:0]      top;
  logic [15:0]      phys_c;
  logic [15:0]      y_norm_r;
  logic             clamped_r;

  assign y_lo = ovr_on ? -`DSC_OVR_MARGIN : 20'sh0;
  assign y_hi = ovr_on ? `DSC_ONE + `DSC_OVR_MARGIN : `DSC_ONE;
  assign y_c  = (fin < y_lo) ? y_lo : (fin > y_hi) ? y_hi : fin;
  // Signed span lets a zero point above full scale invert the output
  assign phys = 37'($signed({1'b0, out_zero_r}))
              + ((37'($signed({1'b0, out_full_r})) - 37'($signed({1'b0, out_zero_r}))) * 37'(y_c) >>> 14);
  assign top  = span_top(range_r, ovr_on);
  assign phys_c = (phys < 37'sh0) ? 16'h0000 : (phys > 37'(top)) ? top : phys[15:0];

  always_ff @(posedge CLK) begin
    if (RESET) begin
      OUT_VALUE      <= 16'h0000;
      OUT_IS_VOLTAGE <= 1'b0;
      OUT_UPDATE     <= 1'b0;
      y_norm_r       <= 16'h0000;
      clamped_r      <= 1'b0;
    end else if (state_r == ST_DONE) begin
      OUT_VALUE      <= phys_c;
      OUT_IS_VOLTAGE <= (range_r >= 3'h3);
      OUT_UPDATE     <= 1'b1;
      y_norm_r       <= y_c[15:0];
      clamped_r      <= (fin != y_c) || (phys != 37'(phys_c));
    end else begin
      OUT_UPDATE     <= 1'b0;
    end
  end

  // ==========================================================
  // Read port, data valid in the cycle after the strobe only
  always_ff @(posedge CLK) begin
    if (RESET || !RD) begin
      RDATA <= 16'h0000;
    end else begin
      case (ADDR)
        `DSC_ADDR_CTRL:     RDATA <= ctrl_r;
        `DSC_ADDR_RANGE:    RDATA <= {13'h0, range_r};
        `DSC_ADDR_GAIN_A:   RDATA <= gain_a_r;
        `DSC_ADDR_GAIN_B:   RDATA <= gain_b_r;
        `DSC_ADDR_OFFSET:   RDATA <= offset_r;
        `DSC_ADDR_OUT_ZERO: RDATA <= out_zero_r;
        `DSC_ADDR_OUT_FULL: RDATA <= out_full_r;
        `DSC_ADDR_PBAND:    RDATA <= pband_r;
        `DSC_ADDR_ITIME:    RDATA <= {12'h0, itime_r};
        `DSC_ADDR_DTIME:    RDATA <= dtime_r;
        `DSC_ADDR_SETPT:    RDATA <= setpt_r;
        `DSC_ADDR_DSHIFT:   RDATA <= {12'h0, dshift_r};
        `DSC_ADDR_RESULT:   RDATA <= y_norm_r;
        `DSC_ADDR_OUTVAL:   RDATA <= OUT_VALUE;
        `DSC_ADDR_STATUS:   RDATA <= {11'h0, (span_top(range_r, 1'b0) == 16'h0), clamped_r,
                                      div_sat_r, dig_s2_r, (state_r != ST_IDLE)};
        default:            RDATA <= 16'h0000;
      endcase
    end
  end

endmodule

// *** hw/dsc_defs.svh ***
// Constants for the dual-input signal calculator core
//
// Function
// - Range codes 1 and 2 select 0-10 mA and 0-20 mA current output.
// - Range codes 3 to 6 select 0.5 V, 1 V, 5 V, 10 V voltage output.
// - Overrange on: span may be exceeded by 3%, within 20.5 mA / 10.25 V.
// - Overrange off: output clamped to the configured span.
// - Function 1: gain_a*A + gain_b*B + offset.
// - Function 2: scaled A minus scaled B, or reverse, plus offset.
// - Functions 3 and 4: max or min of scaled A and B, plus offset.
// - Function 5: gain_a*A*B + offset.
// - Function 6: gain_a*(A/B or B/A) + offset.
// - Function 7: gain_a*(A or B)^gain_b + offset.
// - Inputs and output handled as normalised 0 to 1 values.
// - Offset of 0 to 1 span added; output saturates at span top.
// - Function 8: track input while digital input idle, freeze while active.
// - Sample-hold value kept in non-volatile storage.
// - Function 9: hold largest input seen while digital input idle since last activation; the stored peak comes back after reset.
// - Peak-hold: activation reloads peak with present input.
// - Peak-hold value kept in non-volatile storage.
// - Function 10: first-order exponential filter of selected input.
// - PID direct action: output rises while process above setpoint.
// - PID inverted action: output falls while process above setpoint.
// - Zero integral and derivative times leave proportional term only.
// - Derivative term adds in proportion to process rise rate, and subtracts under inverted action.
// - Zero endpoint above full-scale endpoint inverts output mapping.
// - PID hold with digital input active freezes output and integrator.
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// ==========================================================
// Register offsets
`define DSC_ADDR_CTRL     8'h00
`define DSC_ADDR_RANGE    8'h04
`define DSC_ADDR_GAIN_A   8'h08
`define DSC_ADDR_GAIN_B   8'h0c
`define DSC_ADDR_OFFSET   8'h10
`define DSC_ADDR_OUT_ZERO 8'h14
`define DSC_ADDR_OUT_FULL 8'h18
`define DSC_ADDR_PBAND    8'h1c
`define DSC_ADDR_ITIME    8'h20
`define DSC_ADDR_DTIME    8'h24
`define DSC_ADDR_SETPT    8'h28
`define DSC_ADDR_DSHIFT   8'h2c
`define DSC_ADDR_RESULT   8'h30
`define DSC_ADDR_OUTVAL   8'h34
`define DSC_ADDR_STATUS   8'h38

// ==========================================================
// Control field positions
`define DSC_CTRL_FUNC_HI  4
`define DSC_CTRL_SEL_B    5
`define DSC_CTRL_OVR      6
`define DSC_CTRL_INV      7
`define DSC_CTRL_EXT_SP   8
`define DSC_CTRL_HOLD     9

// ==========================================================
// Reset values
`define DSC_RST_CTRL      16'h0001
`define DSC_RST_RANGE     3'h2
`define DSC_RST_GAIN      16'h1000
`define DSC_RST_OFFSET    16'h0000
`define DSC_RST_OUT_ZERO  16'h0fa0
`define DSC_RST_OUT_FULL  16'h4e20
`define DSC_RST_PBAND     16'h1000
`define DSC_RST_ITIME     4'h0
`define DSC_RST_DTIME     16'h0000
`define DSC_RST_SETPT     16'h2000
`define DSC_RST_DSHIFT    4'h4

// ==========================================================
// Fixed point: values Q6.14 signed, gains Q4.12
`define DSC_ONE           20'sh04000
`define DSC_OVR_MARGIN    20'sh001ec
`define DSC_DIV_MIN       16'h0010
`define DSC_POS_MAX       20'sh7ffff
`define DSC_NEG_MAX       20'sh80000

// ==========================================================
// Physical span tops, uA for current and mV for voltage
`define DSC_TOP_10MA      16'd10000
`define DSC_TOP_20MA      16'd20000
`define DSC_TOP_500MV     16'd500
`define DSC_TOP_1V        16'd1000
`define DSC_TOP_5V        16'd5000
`define DSC_TOP_10V       16'd10000
`define DSC_OTOP_10MA     16'd10300
`define DSC_OTOP_20MA     16'd20500
`define DSC_OTOP_500MV    16'd515
`define DSC_OTOP_1V       16'd1030
`define DSC_OTOP_5V       16'd5150
`define DSC_OTOP_10V      16'd10250

// ==========================================================
// Timing
`define DSC_CLK_KHZ       10000
`define DSC_SAMPLE_US     1000

`endif

// *** hw/dsc_pkg.sv ***
// Types for the dual-input signal calculator core
package dsc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DIV  = 3'b001,
    ST_SQRT = 3'b010,
    ST_POW  = 3'b011,
    ST_DONE = 3'b100
  } dsc_state_t;

  typedef enum logic [4:0] {
    FN_ADD  = 5'b00001,
    FN_SUB  = 5'b00010,
    FN_MAX  = 5'b00011,
    FN_MIN  = 5'b00100,
    FN_MUL  = 5'b00101,
    FN_DIV  = 5'b00110,
    FN_POW  = 5'b00111,
    FN_SH   = 5'b01000,
    FN_PK   = 5'b01001,
    FN_DLY  = 5'b01010,
    FN_PID  = 5'b01011
  } dsc_func_t;

  typedef logic signed [19:0] dsc_val_t;

endpackage

// *** sim/dsc_src.sv ***
// Input transmitters, digital input and non-volatile store at the core's far side
`timescale 1ns/1ps
module dsc_src (
  input  wire logic        clk,
  input  wire logic [15:0] a_set,
  input  wire logic [15:0] b_set,
  input  wire logic        dig_set,
  input  wire logic        nv_wr,
  input  wire logic [15:0] nv_wdata,
  output logic      [15:0] in_a,
  output logic      [15:0] in_b,
  output logic             dig_in,
  output logic      [15:0] nv_rdata
);
  // Levels settle one clock after the bench asks
  always_ff @(posedge clk) begin
    in_a   <= a_set;
    in_b   <= b_set;
    dig_in <= dig_set;
  end
  // Stored word outlives the core's reset, as it would a power loss
  initial nv_rdata = 16'h0000;
  always @(posedge clk) begin
    if (nv_wr) begin
      nv_rdata <= nv_wdata;
    end
  end
endmodule

// *** sim/dsc_core_props.sv ***
// Port assertions for the calculator core
`timescale 1ns/1ps
module dsc_props (
  input wire logic                CLK,
  input wire logic                RESET,
  input wire logic                RD,
  input wire logic [7:0]          ADDR,
  input wire logic [15:0]         RDATA,
  input wire logic                NV_WR,
  input wire logic [15:0]         OUT_VALUE,
  input wire logic                OUT_IS_VOLTAGE,
  input wire logic                OUT_UPDATE,
  input wire dsc_pkg::dsc_state_t STATE
);
  import dsc_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_fin;
    OUT_UPDATE && STATE == ST_IDLE;
  endsequence
  a_done_upd: assert property (STATE == ST_DONE |=> s_fin) else $error("no update after done");
  a_upd_gap: assert property (OUT_UPDATE |=> !OUT_UPDATE [*8]) else $error("updates too close");
  a_out_hold: assert property (!OUT_UPDATE |-> $stable(OUT_VALUE)) else $error("output moved");
  a_vol_top: assert property (OUT_UPDATE && OUT_IS_VOLTAGE |-> OUT_VALUE <= 16'h280a) else $error("volt top");
  a_cur_top: assert property (OUT_UPDATE && !OUT_IS_VOLTAGE |-> OUT_VALUE <= 16'h5014) else $error("amp top");
  a_nv_pulse: assert property (NV_WR |=> !NV_WR) else $error("store strobe too long");
  a_range_rd: assert property ($past(RD) && $past(ADDR) == 8'h04 |-> RDATA[15:3] == 13'h0) else $error("range");
  a_rd_idle: assert property (!$past(RD) |-> RDATA == 16'h0000) else $error("read data left up");
endmodule
bind dsc_core dsc_props u_dsc_props (.CLK(CLK), .RESET(RESET), .RD(RD), .ADDR(ADDR), .RDATA(RDATA), .NV_WR(NV_WR),
  .OUT_VALUE(OUT_VALUE), .OUT_IS_VOLTAGE(OUT_IS_VOLTAGE), .OUT_UPDATE(OUT_UPDATE), .STATE(STATE));

// *** sim/dsc_core_tb.sv ***
// Self-checking bench for the calculator core
`timescale 1ns/1ps
module dsc_core_tb;
  import dsc_pkg::*;
  logic        CLK = 0, RESET = 1, WR = 0, RD = 0, rd_d = 0, dig = 0, NV_WR, OUT_IS_VOLTAGE, OUT_UPDATE, DIG_IN;
  logic [7:0]  ADDR = 0;
  logic [15:0] WDATA = 0, a = 0, b = 0, RDATA, OUT_VALUE, IN_A, IN_B, NV_WDATA, NV_RDATA, q[$];
  dsc_state_t  STATE;
  int          errors = 0, comparisons = 0, r;
  logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h3c};
  logic [15:0] rv[5] = '{16'h0001, 16'h0002, 16'h1000, 16'h0fa0, 16'h0000};
  logic [15:0] fc[10] = '{16'h1, 16'h2, 16'h22, 16'h3, 16'h4, 16'h5, 16'h6, 16'h26, 16'h7, 16'h27};
  logic [15:0] fe[10] = '{16'h3e80, 16'h1f40, 16'h0fa0, 16'h2ee0, 16'h1f40, 16'h1770, 16'h4e20, 16'h2ee0, 16'h2ee0, 16'h1f40};
  dsc_core #(.SAMPLE_CYCLES(50)) u_dsc_core (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IN_A(IN_A), .IN_B(IN_B), .DIG_IN(DIG_IN), .NV_RDATA(NV_RDATA), .NV_WR(NV_WR), .NV_WDATA(NV_WDATA),
    .OUT_VALUE(OUT_VALUE), .OUT_IS_VOLTAGE(OUT_IS_VOLTAGE), .OUT_UPDATE(OUT_UPDATE), .STATE(STATE));
  dsc_src u_dsc_src (.clk(CLK), .a_set(a), .b_set(b), .dig_set(dig), .in_a(IN_A), .in_b(IN_B), .dig_in(DIG_IN),
    .nv_wr(NV_WR), .nv_wdata(NV_WDATA), .nv_rdata(NV_RDATA));
  initial forever #50 CLK = ~CLK;
  // ==========================================================
  // Bus tasks and result checking
  task wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge CLK); ADDR <= ad; WDATA <= d; WR <= 1'b1;
    @(posedge CLK); WR <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [15:0] ex);
    @(posedge CLK); ADDR <= ad; RD <= 1'b1; q.push_back(ex);
    @(posedge CLK); RD <= 1'b0;
  endtask
  // Second update is the first one surely computed with the new setup
  task upd;
    repeat (2) @(posedge CLK iff OUT_UPDATE === 1'b1);
  endtask
  task chk(input logic [15:0] c, input logic [15:0] ex);
    wr(8'h00, c); upd; rd(8'h34, ex);
  endtask
  always @(posedge CLK) begin
    rd_d <= RD;
    if (rd_d) begin
      comparisons++;
      if (RDATA !== q[0]) begin
        errors++; $display("ERROR %0t got %h exp %h", $time, RDATA, q[0]);
      end
      void'(q.pop_front());
    end
  end
  task close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #3ms; errors++; close_out;
  end
  initial begin
    r = $urandom(22);
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    a <= 16'h2000; b <= 16'h1000;
    foreach (fc[i]) chk(fc[i], fe[i]);
    b <= 16'h0000;
    chk(16'h0006, 16'h4e20);
    a <= 16'h1000; wr(8'h0c, 16'h0800);
    chk(16'h0007, 16'h2ee0);
    wr(8'h10, 16'h6000); rd(8'h10, 16'h4000);
    chk(16'h0001, 16'h4e20);
    wr(8'h10, 16'h0000);
    repeat (3) begin
      r = $urandom_range(16384); a <= 16'(r);
      chk(16'h0001, 16'(4000 + 16000 * r / 16384));
    end
    a <= 16'h4000; b <= 16'h4000; wr(8'h04, 16'h0006); wr(8'h14, 16'h0000); wr(8'h18, 16'h2710);
    chk(16'h0001, 16'h2710);
    chk(16'h0041, 16'h280a);
    wr(8'h04, 16'h0002); wr(8'h14, 16'h4e20); wr(8'h18, 16'h0fa0); a <= 16'h1000; b <= 16'h0000;
    chk(16'h0001, 16'h3e80);
    a <= 16'h3000;
    chk(16'h000b, 16'h3e80);
    chk(16'h008b, 16'h4e20);
    a <= 16'h2000;
    chk(16'h0008, 16'h2ee0);
    dig <= 1'b1; upd; a <= 16'h4000; upd;
    rd(8'h34, 16'h2ee0);
    dig <= 1'b0; upd;
    rd(8'h34, 16'h0fa0);
    chk(16'h0009, 16'h0fa0);
    a <= 16'h1000; upd;
    rd(8'h34, 16'h0fa0);
    dig <= 1'b1; upd; dig <= 1'b0; upd;
    rd(8'h34, 16'h3e80);
    // Mid-run reset: the stored peak of 0x1000 must come back from the store
    RESET <= 1'b1;
    a <= 16'h0800;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    wr(8'h2c, 16'h000f);
    chk(16'h0009, 16'h1f40);
    chk(16'h000a, 16'h0fa0);
    wr(8'h2c, 16'h0000);
    chk(16'h000a, 16'h1770);
    a <= 16'h3000;
    chk(16'h020b, 16'h1f40);
    dig <= 1'b1; upd; a <= 16'h2000; upd;
    rd(8'h34, 16'h1f40);
    dig <= 1'b0; wr(8'h24, 16'h1000); upd;
    a <= 16'h3000;
    @(posedge CLK iff OUT_UPDATE === 1'b1);
    rd(8'h34, 16'h2ee0);
    close_out;
  end
endmodule
